// >>> dsr_pkg.sv
// dsr_pkg.sv: constants and types of the display status readback block
// Notes on behaviour
// [R1] command 703002, or 703012 with accumulator zeroing, returns status word one
// [R2] word one bit 2 is high while position offset is enabled
// [R3] word one bit 3 is high while the quarter-turn rotate parameter is active
// [R4] word one bit 4 shows the blink enable
// [R5] word one bits 5-6 give sheet size, bits 7-10 the step magnitude
// [R6] word one bits 11-14 give stop, pen, border and button interrupt enables
// [R7] word one bit 15 shows whether pen hits may raise a flag
// [R8] word one bits 16-17 give the two-bit dash pattern
// [R9] command 703022, or 703032 with zeroing, returns status word two
// [R10] word two bits 0-5 carry the six console button bits
// [R11] word two bits 8-10 carry the intensity, 0 darkest, 7 brightest
// [R12] word two bits 11-17 carry the seven-bit tag value
// [R13] host must not read word two while the display alters button bits
// [R14] command 703142, or 703152 with zeroing, returns word three, six top bits
// [R15] command 703102, or 703112 with zeroing, returns the horizontal position word
// [R16] position word: bits 0-4 zero, bit 5 overrun, bits 6-17 coordinate
// [R17] the horizontal coordinate holds values up to 4095
// [R18] command bit 14 asks for accumulator zeroing, otherwise the host ORs
// [R19] unused bit positions of every returned word read as zero
package dsr_pkg;
	// word width; vector index 17 is the leftmost documented bit 0
	localparam int WORD_W = 18;
	// read command codes with the accumulator-zero option stripped
	localparam logic [17:0] CMD_S1 = 18'h38602;
	localparam logic [17:0] CMD_S2 = 18'h38612;
	localparam logic [17:0] CMD_S3 = 18'h38662;
	localparam logic [17:0] CMD_XPOS = 18'h38642;
	localparam int ACC_ZERO_BIT = 3;
	// word one field positions
	localparam int W1_SHIFT = 15;
	localparam int W1_TURN = 14;
	localparam int W1_FLASH = 13;
	localparam int W1_SHEET_LO = 12;
	localparam int W1_SHEET_HI = 11;
	localparam int W1_STEP_MSB = 10;
	localparam int STEP_W = 4;
	localparam int W1_STOP_IRQ = 6;
	localparam int W1_PEN_IRQ = 5;
	localparam int W1_BORDER_IRQ = 4;
	localparam int W1_BUTTON_IRQ = 3;
	localparam int W1_PEN_FLAG = 2;
	localparam int W1_DASH_MSB = 1;
	localparam int DASH_W = 2;
	// word two field positions
	localparam int W2_BUTTON_MSB = 17;
	localparam int BUTTON_W = 6;
	localparam int W2_BORDER_FLAG = 10;
	localparam int W2_LEVEL_MSB = 9;
	localparam int LEVEL_W = 3;
	localparam int W2_TAG_MSB = 6;
	localparam int TAG_W = 7;
	// word three and position word
	localparam int W3_MSB = 17;
	localparam int W3_W = 6;
	localparam int XP_OVERRUN = 12;
	localparam int XP_COORD_MSB = 11;
	localparam int COORD_W = 12;
	localparam logic [11:0] COORD_MAX = 12'hFFF;
	// values after reset
	localparam logic [17:0] RD_DATA_RST = 18'h00000;
	localparam logic [5:0] BUTTON_RST = 6'h00;
	// which word an answer carries
	typedef enum logic [1:0] {
		DSR_KIND_S1   = 2'h0,
		DSR_KIND_S2   = 2'h1,
		DSR_KIND_S3   = 2'h2,
		DSR_KIND_XPOS = 2'h3
	} dsr_kind_t;
endpackage : dsr_pkg

// >>> dsr_sync3.sv
// dsr_sync3.sv: three-stage synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
module dsr_sync3 #(
	parameter int             WIDTH     = 6,
	parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	if (WIDTH < 1) begin : g_bad_width
		$error("dsr_sync3 width must be at least one");
	end

	// a bit moves only when the second and third stages agree
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
	end

	// shift chain; the first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1_q  <= RST_VALUE;
			s2_q  <= RST_VALUE;
			s3_q  <= RST_VALUE;
			out_q <= RST_VALUE;
		end else begin
			s1_q  <= din;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign dout = out_q;
endmodule : dsr_sync3

// >>> dsr_status_readback.sv
// dsr_status_readback.sv: answers host read commands with formatted status words
`timescale 1ns/10ps
module dsr_status_readback #(
	parameter int BUTTON_W = 6,
	parameter int COORD_W  = 12
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic                io_cmd_valid,
	input  wire logic [17:0]         io_cmd,
	input  wire logic                position_shift_enable,
	input  wire logic                quarter_turn_bit,
	input  wire logic                flash_enable,
	input  wire logic                sheet_size_low,
	input  wire logic                sheet_size_high,
	input  wire logic [3:0]          step_magnitude,
	input  wire logic                stop_irq_enable,
	input  wire logic                pen_hit_irq_enable,
	input  wire logic                border_irq_enable,
	input  wire logic                button_irq_enable,
	input  wire logic                pen_hit_flag_enable,
	input  wire logic [1:0]          dash_pattern,
	input  wire logic [BUTTON_W-1:0] console_button_bits,
	input  wire logic                border_flag_enable,
	input  wire logic [2:0]          intensity_level,
	input  wire logic [6:0]          tag_value,
	input  wire logic [5:0]          status_three_bits,
	input  wire logic                horizontal_overrun,
	input  wire logic [COORD_W-1:0]  horizontal_coord,
	output logic      [17:0]         io_rd_data,
	output logic                     io_rd_valid,
	output logic                     accumulator_zero_option
);
	logic [17:0]           cmd_base;
	logic                  take_s1;
	logic                  take_s2;
	logic                  take_s3;
	logic                  take_xpos;
	logic                  take_any;
	logic [BUTTON_W-1:0]   button_sync;
	logic [17:0]           word_one;
	logic [17:0]           word_two;
	logic [17:0]           word_three;
	logic [17:0]           word_xpos;
	logic [17:0]           word_sel;
	dsr_pkg::dsr_kind_t    kind_sel;
	logic [17:0]           rd_data_q;
	logic [17:0]           rd_data_d;
	logic                  rd_valid_q;
	logic                  acc_zero_q;
	logic                  acc_zero_d;
	dsr_pkg::dsr_kind_t    kind_q;

	// formats are fixed, so only the documented widths can be served
	if (BUTTON_W != dsr_pkg::BUTTON_W) begin : g_bad_buttons
		$error("button width must match the status word layout");
	end
	if (COORD_W != dsr_pkg::COORD_W) begin : g_bad_coord
		$error("coordinate width must match the position word layout");
	end

	// compares a command, zeroing option masked, with a read code
	function automatic logic cmd_is(input logic [17:0] cmd, input logic [17:0] code);
		logic [17:0] base;
		base = cmd;
		base[dsr_pkg::ACC_ZERO_BIT] = 1'b0;
		return base == code;
	endfunction : cmd_is

	// button bits may change under a running display file, so sync them
	dsr_sync3 #(
		.WIDTH     (BUTTON_W),
		.RST_VALUE (dsr_pkg::BUTTON_RST)
	) u_button_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     (console_button_bits),
		.dout    (button_sync)
	);

	// command decode
	assign cmd_base   = io_cmd & ~(18'h00001 << dsr_pkg::ACC_ZERO_BIT);
	assign take_s1    = io_cmd_valid && cmd_is(io_cmd, dsr_pkg::CMD_S1); // R1
	assign take_s2    = io_cmd_valid && cmd_is(io_cmd, dsr_pkg::CMD_S2); // R9
	assign take_s3    = io_cmd_valid && cmd_is(io_cmd, dsr_pkg::CMD_S3); // R14
	assign take_xpos  = io_cmd_valid && cmd_is(io_cmd, dsr_pkg::CMD_XPOS); // R15
	assign take_any   = take_s1 || take_s2 || take_s3 || take_xpos;
	assign acc_zero_d = io_cmd[dsr_pkg::ACC_ZERO_BIT]; // R18

	// status word one; untouched positions stay zero
	always_comb begin
		word_one = '0; // R19
		word_one[dsr_pkg::W1_SHIFT] = position_shift_enable; // R2
		word_one[dsr_pkg::W1_TURN] = quarter_turn_bit; // R3
		word_one[dsr_pkg::W1_FLASH] = flash_enable; // R4
		word_one[dsr_pkg::W1_SHEET_LO] = sheet_size_low; // R5
		word_one[dsr_pkg::W1_SHEET_HI] = sheet_size_high; // R5
		word_one[dsr_pkg::W1_STEP_MSB -: dsr_pkg::STEP_W] = step_magnitude; // R5
		word_one[dsr_pkg::W1_STOP_IRQ] = stop_irq_enable; // R6
		word_one[dsr_pkg::W1_PEN_IRQ] = pen_hit_irq_enable; // R6
		word_one[dsr_pkg::W1_BORDER_IRQ] = border_irq_enable; // R6
		word_one[dsr_pkg::W1_BUTTON_IRQ] = button_irq_enable; // R6
		word_one[dsr_pkg::W1_PEN_FLAG] = pen_hit_flag_enable; // R7
		word_one[dsr_pkg::W1_DASH_MSB -: dsr_pkg::DASH_W] = dash_pattern; // R8
	end

	// status word two; position 6 stays zero
	always_comb begin
		word_two = '0; // R19
		word_two[dsr_pkg::W2_BUTTON_MSB -: dsr_pkg::BUTTON_W] = button_sync; // R10
		word_two[dsr_pkg::W2_BORDER_FLAG] = border_flag_enable;
		word_two[dsr_pkg::W2_LEVEL_MSB -: dsr_pkg::LEVEL_W] = intensity_level; // R11
		word_two[dsr_pkg::W2_TAG_MSB -: dsr_pkg::TAG_W] = tag_value; // R12
	end

	// status word three and the horizontal position word
	always_comb begin
		word_three = '0; // R19
		word_three[dsr_pkg::W3_MSB -: dsr_pkg::W3_W] = status_three_bits; // R14
		word_xpos = '0; // R16
		word_xpos[dsr_pkg::XP_OVERRUN] = horizontal_overrun; // R16
		word_xpos[dsr_pkg::XP_COORD_MSB -: dsr_pkg::COORD_W] = horizontal_coord; // R17
	end

	// word and kind selection
	assign word_sel = take_s1 ? word_one :
	                  take_s2 ? word_two :
	                  take_s3 ? word_three : word_xpos;
	assign kind_sel = take_s1 ? dsr_pkg::DSR_KIND_S1 :
	                  take_s2 ? dsr_pkg::DSR_KIND_S2 :
	                  take_s3 ? dsr_pkg::DSR_KIND_S3 : dsr_pkg::DSR_KIND_XPOS;
	assign rd_data_d = take_any ? word_sel : dsr_pkg::RD_DATA_RST;

	// answer register: one cycle after the command, zero when idle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_data_q  <= dsr_pkg::RD_DATA_RST;
			rd_valid_q <= 1'b0;
			acc_zero_q <= 1'b0;
			kind_q     <= dsr_pkg::DSR_KIND_S1;
		end else begin
			rd_data_q  <= rd_data_d; // R1
			rd_valid_q <= take_any;
			acc_zero_q <= take_any && acc_zero_d; // R18
			kind_q     <= take_any ? kind_sel : kind_q;
		end
	end

	assign io_rd_data              = rd_data_q;
	assign io_rd_valid             = rd_valid_q;
	assign accumulator_zero_option = acc_zero_q;

	// answer kinds seen by the checks below
	logic rd_s1;
	logic rd_s2;
	logic rd_s3;
	logic rd_xp;
	assign rd_s1 = rd_valid_q && kind_q == dsr_pkg::DSR_KIND_S1;
	assign rd_s2 = rd_valid_q && kind_q == dsr_pkg::DSR_KIND_S2;
	assign rd_s3 = rd_valid_q && kind_q == dsr_pkg::DSR_KIND_S3;
	assign rd_xp = rd_valid_q && kind_q == dsr_pkg::DSR_KIND_XPOS;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	AST_S1_ANSWER: assert property ( // R1
		io_cmd_valid && cmd_base == dsr_pkg::CMD_S1 |=> rd_s1 && io_rd_data == $past(word_one))
		else $error("word one not returned after its command");
	AST_SHIFT_BIT: assert property ( // R2
		rd_s1 |-> io_rd_data[dsr_pkg::W1_SHIFT] == $past(position_shift_enable))
		else $error("offset bit does not follow its parameter");
	AST_TURN_BIT: assert property ( // R3
		rd_s1 |-> io_rd_data[dsr_pkg::W1_TURN] == $past(quarter_turn_bit))
		else $error("rotate bit does not follow its parameter");
	AST_FLASH_BIT: assert property ( // R4
		rd_s1 |-> io_rd_data[dsr_pkg::W1_FLASH] == $past(flash_enable))
		else $error("blink bit does not follow its parameter");
	AST_SHEET_STEP: assert property ( // R5
		rd_s1 |-> io_rd_data[dsr_pkg::W1_SHEET_LO] == $past(sheet_size_low)
			&& io_rd_data[dsr_pkg::W1_SHEET_HI] == $past(sheet_size_high)
			&& io_rd_data[dsr_pkg::W1_STEP_MSB -: dsr_pkg::STEP_W] == $past(step_magnitude))
		else $error("sheet size or step field wrong");
	AST_IRQ_ENABLES: assert property ( // R6
		rd_s1 |-> io_rd_data[dsr_pkg::W1_STOP_IRQ -: 4] == $past({stop_irq_enable,
			pen_hit_irq_enable, border_irq_enable, button_irq_enable}))
		else $error("interrupt enable field wrong");
	AST_PEN_FLAG: assert property ( // R7
		rd_s1 |-> io_rd_data[dsr_pkg::W1_PEN_FLAG] == $past(pen_hit_flag_enable))
		else $error("pen flag enable bit wrong");
	AST_DASH: assert property ( // R8
		rd_s1 |-> io_rd_data[dsr_pkg::W1_DASH_MSB -: dsr_pkg::DASH_W] == $past(dash_pattern))
		else $error("dash pattern field wrong");
	AST_S2_ANSWER: assert property ( // R9
		io_cmd_valid && cmd_base == dsr_pkg::CMD_S2 |=> rd_s2)
		else $error("word two not returned after its command");
	AST_BUTTONS: assert property ( // R10
		rd_s2 |-> io_rd_data[dsr_pkg::W2_BUTTON_MSB -: dsr_pkg::BUTTON_W] == $past(button_sync))
		else $error("button field wrong");
	AST_LEVEL: assert property ( // R11
		rd_s2 |-> io_rd_data[dsr_pkg::W2_LEVEL_MSB -: dsr_pkg::LEVEL_W] == $past(intensity_level))
		else $error("intensity field wrong");
	AST_TAG: assert property ( // R12
		rd_s2 |-> io_rd_data[dsr_pkg::W2_TAG_MSB -: dsr_pkg::TAG_W] == $past(tag_value))
		else $error("tag field wrong");
	AST_S3_ANSWER: assert property ( // R14
		io_cmd_valid && cmd_base == dsr_pkg::CMD_S3 |=> rd_s3
			&& io_rd_data[dsr_pkg::W3_MSB -: dsr_pkg::W3_W] == $past(status_three_bits))
		else $error("word three not returned after its command");
	AST_XP_ANSWER: assert property ( // R15
		io_cmd_valid && cmd_base == dsr_pkg::CMD_XPOS |=> rd_xp)
		else $error("position word not returned after its command");
	AST_XP_FORMAT: assert property ( // R16
		rd_xp |-> io_rd_data[dsr_pkg::XP_OVERRUN] == $past(horizontal_overrun)
			&& io_rd_data[dsr_pkg::XP_COORD_MSB -: dsr_pkg::COORD_W] == $past(horizontal_coord))
		else $error("position word layout wrong");
	AST_XP_MAX: assert property ( // R17
		io_cmd_valid && cmd_base == dsr_pkg::CMD_XPOS && horizontal_coord == dsr_pkg::COORD_MAX
			|=> io_rd_data[dsr_pkg::XP_COORD_MSB -: dsr_pkg::COORD_W] == dsr_pkg::COORD_MAX)
		else $error("largest coordinate not returned whole");
	AST_ACC_ZERO: assert property ( // R18
		io_rd_valid |-> accumulator_zero_option == $past(io_cmd[dsr_pkg::ACC_ZERO_BIT]))
		else $error("zeroing request does not follow the command");
	AST_UNUSED_ZERO: assert property ( // R19
		io_rd_valid |-> io_rd_data[17:16] == 2'h0 || !rd_s1)
		else $error("unused bits of word one not zero");
	AST_XP_UNUSED: assert property ( // R19
		rd_xp |-> io_rd_data[17:13] == 5'h00)
		else $error("unused bits of position word not zero");
	AST_IDLE_QUIET: assert property ( // R19
		!io_rd_valid |-> io_rd_data == dsr_pkg::RD_DATA_RST && !accumulator_zero_option)
		else $error("outputs not quiet without an answer");
	AST_NO_STRAY: assert property ( // R1
		io_cmd_valid && !take_any ##1 1'b1 |-> !io_rd_valid)
		else $error("answer to an unknown command");

	// whole words two, three and position, then the border flag and overrun bits
	AST_S2_WORD: assert property ( // R9
		take_s2 |=> io_rd_data == $past(word_two))
		else $error("word two data wrong");
	AST_S3_WORD: assert property ( // R14
		take_s3 |=> io_rd_data == $past(word_three))
		else $error("word three data wrong");
	AST_XP_WORD: assert property ( // R15
		take_xpos |=> io_rd_data == $past(word_xpos))
		else $error("position word data wrong");
	AST_BORDER_FLAG: assert property ( // R9
		rd_s2 |-> io_rd_data[dsr_pkg::W2_BORDER_FLAG] == $past(border_flag_enable))
		else $error("border flag bit wrong");
	AST_XP_OVERRUN_SET: assert property ( // R16
		take_xpos && horizontal_overrun |=> io_rd_data[dsr_pkg::XP_OVERRUN])
		else $error("overrun not reported");
	AST_XP_OVERRUN_CLR: assert property ( // R16
		take_xpos && !horizontal_overrun |=> !io_rd_data[dsr_pkg::XP_OVERRUN])
		else $error("overrun reported without cause");

	// positions that carry nothing read as zero
	AST_S2_GAP: assert property ( // R19
		rd_s2 |-> io_rd_data[dsr_pkg::W2_BUTTON_MSB - dsr_pkg::BUTTON_W] == 1'b0)
		else $error("gap bit of word two not zero");
	AST_S3_LOW_ZERO: assert property ( // R14
		rd_s3 |-> io_rd_data[dsr_pkg::W3_MSB - dsr_pkg::W3_W : 0] == '0)
		else $error("low bits of word three not zero");
	AST_STRAY_DATA: assert property ( // R19
		io_cmd_valid && !take_any |=> io_rd_data == dsr_pkg::RD_DATA_RST && !accumulator_zero_option)
		else $error("refused command left data");
	AST_DATA_ONLY_VALID: assert property ( // R19
		io_rd_data != dsr_pkg::RD_DATA_RST |-> io_rd_valid)
		else $error("data without an answer strobe");
	AST_RESET_QUIET: assert property ( // R19
		disable iff (1'b0) !rst_n |=> !io_rd_valid && !accumulator_zero_option
			&& io_rd_data == dsr_pkg::RD_DATA_RST)
		else $error("outputs not cleared by reset");

	// decode, strobe timing and answer kind
	AST_STROBE_GATES: assert property ( // R1
		!io_cmd_valid |-> !take_any)
		else $error("command taken without its strobe");
	AST_OTHER_IOP: assert property ( // R1
		io_cmd[2:0] != dsr_pkg::CMD_S1[2:0] |-> !take_any)
		else $error("command with other pulse bits taken");
	AST_OTHER_DEVICE: assert property ( // R1
		io_cmd[17:7] != dsr_pkg::CMD_S1[17:7] |-> !take_any)
		else $error("command for another device taken");
	AST_DECODE_ONEHOT: assert property ( // R1
		$onehot0({take_s1, take_s2, take_s3, take_xpos}))
		else $error("one command decoded as two reads");
	AST_VALID_FROM_CMD: assert property ( // R1
		io_rd_valid |-> $past(take_any))
		else $error("answer without a command");
	AST_ONE_CYCLE: assert property ( // R1
		io_rd_valid && !take_any |=> !io_rd_valid)
		else $error("answer strobe stands too long");
	AST_IDLE_FOLLOWS: assert property ( // R1
		!io_cmd_valid |=> !io_rd_valid)
		else $error("answer after an idle cycle");
	AST_TWO_IN_ROW: assert property ( // R1
		take_any ##1 take_any |=> io_rd_valid)
		else $error("second of two commands not answered");
	AST_S1_FROM: assert property ( // R1
		rd_s1 |-> $past(take_s1))
		else $error("word one without its command");
	AST_S2_FROM: assert property ( // R9
		rd_s2 |-> $past(take_s2))
		else $error("word two without its command");
	AST_S3_FROM: assert property ( // R14
		rd_s3 |-> $past(take_s3))
		else $error("word three without its command");
	AST_XP_FROM: assert property ( // R15
		rd_xp |-> $past(take_xpos))
		else $error("position word without its command");

	// accumulator zeroing request
	AST_ZERO_NEEDS_VALID: assert property ( // R18
		accumulator_zero_option |-> io_rd_valid)
		else $error("zeroing request without an answer");
	AST_ZERO_CLR: assert property ( // R18
		take_any && !acc_zero_d |=> io_rd_valid && !accumulator_zero_option)
		else $error("zeroing requested by a plain read");
	AST_S1_ZERO: assert property ( // R18
		take_s1 && acc_zero_d |=> rd_s1 && accumulator_zero_option)
		else $error("word one zeroing lost");
	AST_S2_ZERO: assert property ( // R18
		take_s2 && acc_zero_d |=> rd_s2 && accumulator_zero_option)
		else $error("word two zeroing lost");
	AST_S3_ZERO: assert property ( // R18
		take_s3 && acc_zero_d |=> rd_s3 && accumulator_zero_option)
		else $error("word three zeroing lost");
	AST_XP_ZERO: assert property ( // R18
		take_xpos && acc_zero_d |=> rd_xp && accumulator_zero_option)
		else $error("position word zeroing lost");

	// button synchroniser
	AST_BUTTON_LAG: assert property ( // R10
		((button_sync ^ $past(button_sync)) & (button_sync ^ $past(console_button_bits, 3))) == '0)
		else $error("button bit moved before its lines settled");
	AST_BUTTON_SETTLE: assert property ( // R10
		$stable(console_button_bits) [*5] |-> button_sync == console_button_bits)
		else $error("button bits not settled after quiet lines");

	CVR_S1_ZERO: cover property (take_s1 && acc_zero_d ##1 io_rd_valid);
	CVR_S2_OR: cover property (take_s2 && !acc_zero_d ##1 io_rd_valid);
	CVR_BACK_TO_BACK: cover property (take_s3 ##1 take_xpos ##1 rd_xp);
	CVR_XP_OVERRUN: cover property (take_xpos && horizontal_overrun);
	CVR_BUTTON_MOVE: cover property ($changed(button_sync) ##[1:20] rd_s2);
endmodule : dsr_status_readback

// >>> dsr_host_model.sv
// dsr_host_model.sv: host side model that issues read commands and keeps the accumulator
`timescale 1ns/10ps
module dsr_host_model (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	output logic             io_cmd_valid,
	output logic [17:0]      io_cmd,
	input  wire logic [17:0] io_rd_data,
	input  wire logic        io_rd_valid,
	input  wire logic        accumulator_zero_option,
	output logic [17:0]      acc_q,
	output logic [7:0]       n_ans_q
);
	// command lines idle low at start
	initial begin
		io_cmd_valid = 1'b0;
		io_cmd       = 18'h00000;
	end
	// accumulator: zeroed first on request, otherwise the answer is ORed in
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			acc_q   <= 18'h00000;
			n_ans_q <= 8'h00;
		end else if (io_rd_valid) begin
			acc_q   <= (accumulator_zero_option ? 18'h00000 : acc_q) | io_rd_data;
			n_ans_q <= n_ans_q + 8'h01;
		end
	end
	// one or two commands on consecutive edges, then time the answer to the last one
	task automatic issue(input logic [17:0] c0, input logic [17:0] c1, input bit two, output int lat);
		@(posedge sys_clk);
		io_cmd_valid <= 1'b1;
		io_cmd       <= c0;
		if (two) begin
			@(posedge sys_clk);
			io_cmd <= c1;
		end
		@(posedge sys_clk);
		io_cmd_valid <= 1'b0;
		io_cmd       <= ~io_cmd; // released lines do not keep the last value
		lat = 0;
		for (int i = 1; i <= 3 && lat == 0; i++) begin
			#1;
			if (io_rd_valid === 1'b1) lat = i;
			else @(posedge sys_clk);
		end
		// let the accumulator take the answer
		@(posedge sys_clk);
		#1;
	endtask : issue
endmodule : dsr_host_model

// >>> dsr_status_readback_bench.sv
// dsr_status_readback_bench.sv: self-checking bench of the status readback block
`timescale 1ns/10ps
module dsr_status_readback_bench;
	logic        sys_clk;
	logic        rst_n;
	logic [51:0] stim;
	logic        io_cmd_valid;
	logic [17:0] io_cmd;
	logic [17:0] io_rd_data;
	logic        io_rd_valid;
	logic        accumulator_zero_option;
	logic [17:0] acc_q;
	logic [7:0]  n_ans_q;
	int          mismatches;
	int          n_tests;
	int          cycles;
	logic [51:0] pats [4];
	// clock and run-time ceiling
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	dsr_status_readback dut (.sys_clk(sys_clk), .rst_n(rst_n), .io_cmd_valid(io_cmd_valid), .io_cmd(io_cmd),
		.position_shift_enable(stim[0]), .quarter_turn_bit(stim[1]), .flash_enable(stim[2]),
		.sheet_size_low(stim[3]), .sheet_size_high(stim[4]), .step_magnitude(stim[8:5]),
		.stop_irq_enable(stim[9]), .pen_hit_irq_enable(stim[10]), .border_irq_enable(stim[11]),
		.button_irq_enable(stim[12]), .pen_hit_flag_enable(stim[13]), .dash_pattern(stim[15:14]),
		.console_button_bits(stim[21:16]), .border_flag_enable(stim[22]), .intensity_level(stim[25:23]),
		.tag_value(stim[32:26]), .status_three_bits(stim[38:33]), .horizontal_overrun(stim[39]),
		.horizontal_coord(stim[51:40]), .io_rd_data(io_rd_data), .io_rd_valid(io_rd_valid),
		.accumulator_zero_option(accumulator_zero_option));
	dsr_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .io_cmd_valid(io_cmd_valid), .io_cmd(io_cmd),
		.io_rd_data(io_rd_data), .io_rd_valid(io_rd_valid), .accumulator_zero_option(accumulator_zero_option),
		.acc_q(acc_q), .n_ans_q(n_ans_q));
	// place a field whose first (most significant) bit is bit k of the word, bit 0 leftmost
	function automatic logic [17:0] put(input logic [11:0] v, input int k, input int w);
		return 18'(v) << (18 - k - w);
	endfunction : put
	// expected answer words from the status levels
	function automatic logic [17:0] word(input logic [51:0] s, input int kind);
		case (kind)
			0: return put(12'(s[0]), 2, 1) | put(12'(s[1]), 3, 1) | put(12'(s[2]), 4, 1) | put(12'(s[3]), 5, 1)
				| put(12'(s[4]), 6, 1) | put(12'(s[8:5]), 7, 4) | put(12'(s[9]), 11, 1) | put(12'(s[10]), 12, 1)
				| put(12'(s[11]), 13, 1) | put(12'(s[12]), 14, 1) | put(12'(s[13]), 15, 1) | put(12'(s[15:14]), 16, 2);
			1: return put(12'(s[21:16]), 0, 6) | put(12'(s[22]), 7, 1) | put(12'(s[25:23]), 8, 3)
				| put(12'(s[32:26]), 11, 7);
			2: return put(12'(s[38:33]), 0, 6);
			default: return put(12'(s[39]), 5, 1) | put(s[51:40], 6, 12);
		endcase
	endfunction : word
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// set status levels and let the button synchroniser settle before any read
	task automatic set_stim(input logic [51:0] v);
		@(posedge sys_clk);
		stim <= v;
		repeat (6) @(posedge sys_clk);
	endtask : set_stim
	// one read, answer one cycle later, accumulator as expected
	task automatic read_check(input logic [17:0] cmd, input logic [17:0] exp_acc);
		int lat;
		host.issue(cmd, cmd, 1'b0, lat);
		check(18'(lat), 18'h00001);
		check(acc_q, exp_acc);
	endtask : read_check
	// every read code with and without zeroing, over bit patterns incl. coordinate 4095
	task automatic t_reads;
		logic [51:0] s;
		for (int p = 0; p < 4; p++) begin
			s = pats[p];
			set_stim(s);
			read_check(18'h3860A, word(s, 0));
			read_check(18'h3861A, word(s, 1));
			read_check(18'h3866A, word(s, 2));
			read_check(18'h3864A, word(s, 3));
			read_check(18'h38602, word(s, 3) | word(s, 0));
			read_check(18'h38612, word(s, 3) | word(s, 0) | word(s, 1));
			read_check(18'h38662, word(s, 3) | word(s, 0) | word(s, 1) | word(s, 2));
			read_check(18'h38642, word(s, 3) | word(s, 0) | word(s, 1) | word(s, 2));
		end
	endtask : t_reads
	// other device, other pulse bits: no answer, accumulator untouched
	task automatic t_refuse;
		logic [17:0] bad [3];
		logic [17:0] acc0;
		int          lat;
		bad  = '{18'h38606, 18'h38802, 18'h38603};
		acc0 = acc_q;
		for (int i = 0; i < 3; i++) begin
			host.issue(bad[i], bad[i], 1'b0, lat);
			check(18'(lat), 18'h00000);
			check(acc_q, acc0);
		end
	endtask : t_refuse
	// two commands on consecutive edges each get an answer
	task automatic t_back_to_back;
		logic [7:0] n0;
		int         lat;
		set_stim(pats[0]);
		n0 = n_ans_q;
		host.issue(18'h3860A, 18'h38642, 1'b1, lat);
		check(18'(lat), 18'h00001);
		check(18'(n_ans_q - n0), 18'h00002);
		check(acc_q, word(stim, 0) | word(stim, 3));
	endtask : t_back_to_back
	task automatic report_and_stop;
		if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	// main sequence
	initial begin
		rst_n      = 1'b0;
		stim       = 52'h0_0000_0000_0000;
		mismatches = 0;
		n_tests    = 0;
		cycles     = 0;
		pats       = '{52'hA_5A5A_5A5A_5A5A, 52'h5_A5A5_A5A5_A5A5, 52'hF_FFFF_FFFF_FFFF, 52'h0_0000_0000_0000};
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		check({io_rd_valid, accumulator_zero_option, 16'h0000}, 18'h00000);
		check(io_rd_data, 18'h00000);
		t_reads();
		t_refuse();
		t_back_to_back();
		report_and_stop();
	end
endmodule : dsr_status_readback_bench
